// file: design/hmd_classify.sv
module hmd_classify (
   // header in
   input  wire logic [7:0]         header,
   input  wire logic               started,
   // decode out
   output hmd_pkg::hmd_class_t     msg_class,
   output logic [1:0]              target_block
);
   logic [1:0] path_select;
   logic [3:0] message_type;
   logic [5:0] code;
   always_comb begin
      path_select  = header[hmd_pkg::PATH_HI:hmd_pkg::PATH_LO]; // [R3]
      message_type = header[hmd_pkg::TYPE_HI:hmd_pkg::TYPE_LO];
      code         = header[hmd_pkg::TYPE_HI:hmd_pkg::BLK_LO];
      target_block = header[hmd_pkg::BLK_HI:hmd_pkg::BLK_LO]; // [R4]
      msg_class    = hmd_pkg::HMD_INVALID; // [R16]
      if (path_select == hmd_pkg::PATH_ONE ||
          path_select == hmd_pkg::PATH_TWO) begin
         if (code == hmd_pkg::CODE_CTRL_TX) begin
            msg_class = hmd_pkg::HMD_CTRL_TX; // [R6]
         end else begin
            unique case (message_type) // [R5]
               hmd_pkg::TYP_CFG_REQ:  msg_class = hmd_pkg::HMD_CFG_REQ;
               hmd_pkg::TYP_STAT_REQ: msg_class = hmd_pkg::HMD_STAT_REQ;
               hmd_pkg::TYP_CFG_SET:  msg_class = hmd_pkg::HMD_CFG_SET;
               hmd_pkg::TYP_CTRL:     msg_class = hmd_pkg::HMD_CTRL;
               default:               msg_class = hmd_pkg::HMD_INVALID;
            endcase
         end
      end else if (path_select == hmd_pkg::PATH_TEST) begin
         // whole six bits are one code here
         unique case (code) // [R7] [R8]
            hmd_pkg::T_CFG_SET:   msg_class = hmd_pkg::HMD_CFG_SET;
            hmd_pkg::T_CTRL:      msg_class = hmd_pkg::HMD_CTRL;
            hmd_pkg::T_STAT_REQ:  msg_class = hmd_pkg::HMD_STAT_REQ;
            hmd_pkg::T_WAIT_CFG:  msg_class = hmd_pkg::HMD_WAIT_CFG;
            hmd_pkg::T_TIMER_CFG: msg_class = hmd_pkg::HMD_TIMER_CFG;
            hmd_pkg::T_SELFTEST:  msg_class = hmd_pkg::HMD_SELFTEST;
            hmd_pkg::T_CHIP_VER:  msg_class = started ? // [R9]
               hmd_pkg::HMD_INVALID : hmd_pkg::HMD_CHIP_VER;
            hmd_pkg::T_KEY:       msg_class = started ?
               hmd_pkg::HMD_INVALID : hmd_pkg::HMD_KEY;
            hmd_pkg::T_PROG:      msg_class = started ?
               hmd_pkg::HMD_INVALID : hmd_pkg::HMD_PROG;
            hmd_pkg::T_START:     msg_class = started ?
               hmd_pkg::HMD_INVALID : hmd_pkg::HMD_START;
            default:              msg_class = hmd_pkg::HMD_INVALID;
         endcase
      end
   end
endmodule

// file: design/hmd_decoder.sv
// How it works
// [R1] header byte, then control high, then low
// [R2] parameter bytes follow the three header bytes
// [R3] top two header bits choose the path
// [R4] low two bits choose target block
// [R5] bits five to two give message type
// [R6] code 100000 means control with transmit data
// [R7] path zero reads six bits as one code
// [R8] path zero decodes ten listed test codes
// [R9] download codes valid only before program start
// [R10] pump status request returns mode and direction
// [R11] pump events reported to host as status
// [R12] timeslot setup stores length and position
// [R13] configuration request answered with current settings
// [R14] host clears read pointer before mailbox reads
// [R15] host clearing acknowledge releases whole mailbox; the code clears only ack and keeps the answer byte
// [R16] unlisted header answered invalid on path zero
//
// Our own choices: register access over AHB-Lite and the register addresses.
module hmd_decoder #(
   parameter int DEPTH = hmd_pkg::PARAM_DEPTH
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // pump event input from the data pump
   input  wire logic        pump_event,
   input  wire logic [7:0]  pump_event_code,
   // decoded message out
   output logic             msg_valid,
   output logic [7:0]       msg_class_out,
   output logic [1:0]       msg_path,
   output logic [1:0]       msg_block,
   output logic             program_started
);
   typedef enum logic [1:0] {
      HMD_WAIT_HDR, HMD_WAIT_HI, HMD_WAIT_LO, HMD_PARAMS
   } hmd_state_t;

   // bus address phase capture
   logic       ap_wr;
   logic       ap_rd;
   logic [7:0] ap_addr;
   logic       next_ap_wr;
   logic       next_ap_rd;
   logic [7:0] next_ap_addr;

   // framing state
   hmd_state_t state;
   hmd_state_t next_state;
   logic [7:0] header;
   logic [7:0] next_header;
   logic [7:0] ctrl_hi;
   logic [7:0] next_ctrl_hi;
   logic [7:0] param_count;
   logic [7:0] next_param_count;
   logic [7:0] param_idx;
   logic [7:0] next_param_idx;
   logic [7:0] params [DEPTH];
   logic       pwr_en;
   logic [5:0] pwr_idx;

   // answer mailbox and device state
   logic [7:0] answer;
   logic [7:0] next_answer;
   logic       ack;
   logic       next_ack;
   logic       started;
   logic       next_started;
   logic [7:0] pump_mode;
   logic [7:0] next_pump_mode;
   logic [7:0] slot_cfg;
   logic [7:0] next_slot_cfg;
   logic [7:0] event_code;
   logic [7:0] next_event_code;
   logic       valid_q;
   logic       next_valid;
   logic [7:0] cls_q;
   logic [7:0] next_cls;

   hmd_pkg::hmd_class_t cls;
   logic [1:0]          blk;

   hmd_classify u_classify (
      .header       (header),
      .started      (started),
      .msg_class    (cls),
      .target_block (blk)
   );

   logic wr_now;
   logic [7:0] wbyte;
   always_comb begin
      next_ap_wr   = hsel && hready && htrans[1] && hwrite;
      next_ap_rd   = hsel && hready && htrans[1] && !hwrite;
      next_ap_addr = hready ? haddr : ap_addr;
      if (!hready) begin
         next_ap_wr = ap_wr;
         next_ap_rd = ap_rd;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr   <= 1'b0;
         ap_rd   <= 1'b0;
         ap_addr <= 8'h00;
      end else begin
         ap_wr   <= next_ap_wr;
         ap_rd   <= next_ap_rd;
         ap_addr <= next_ap_addr;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign wr_now    = ap_wr;
   assign wbyte     = hwdata[7:0];

   always_comb begin
      next_state       = state;
      next_header      = header;
      next_ctrl_hi     = ctrl_hi;
      next_param_count = param_count;
      next_param_idx   = param_idx;
      next_answer      = answer;
      next_ack         = ack;
      next_started     = started;
      next_pump_mode   = pump_mode;
      next_slot_cfg    = slot_cfg;
      next_event_code  = event_code;
      next_valid       = 1'b0;
      next_cls         = cls_q;
      pwr_en           = 1'b0;
      pwr_idx          = param_idx[5:0];
      // event set beats the host clear of the acknowledge
      if (wr_now && ap_addr == hmd_pkg::OFS_ACK && !wbyte[0]) begin
         next_ack = 1'b0; // [R15]
      end
      if (pump_event) begin
         next_event_code = pump_event_code;
         next_answer     = {hmd_pkg::PATH_ONE, hmd_pkg::ANS_EVENT,
                            hmd_pkg::BLK_PUMP}; // [R11]
         next_ack        = 1'b1;
      end
      if (wr_now) begin
         unique case (state) // [R1]
            HMD_WAIT_HDR: if (ap_addr == hmd_pkg::OFS_HEADER) begin
               next_header = wbyte;
               next_state  = HMD_WAIT_HI;
            end
            HMD_WAIT_HI: if (ap_addr == hmd_pkg::OFS_CTRL) begin
               next_ctrl_hi = wbyte;
               next_state   = HMD_WAIT_LO;
            end
            HMD_WAIT_LO: if (ap_addr == hmd_pkg::OFS_CTRL) begin
               next_param_count = wbyte;
               next_param_idx   = 8'h00;
               next_state       = (wbyte == 8'h00) ? HMD_WAIT_HDR
                                                   : HMD_PARAMS;
               next_valid       = (wbyte == 8'h00);
            end
            HMD_PARAMS: if (ap_addr == hmd_pkg::OFS_PARAM) begin
               pwr_en         = 1'b1; // [R2]
               next_param_idx = param_idx + 8'h01;
               if (param_idx + 8'h01 == param_count) begin
                  next_state = HMD_WAIT_HDR;
                  next_valid = 1'b1;
               end
            end
         endcase
      end
      if (next_valid) begin
         next_cls = {4'h0, cls};
         unique case (cls)
            hmd_pkg::HMD_START: next_started = 1'b1;
            hmd_pkg::HMD_INVALID: begin
               next_answer = hmd_pkg::ANS_INVALID; // [R16]
               next_ack    = 1'b1;
            end
            hmd_pkg::HMD_CFG_REQ: begin
               next_answer = {header[7:6], hmd_pkg::ANS_CFG, blk}; // [R13]
               next_ack    = 1'b1;
            end
            hmd_pkg::HMD_STAT_REQ: begin
               next_answer = (header[7:6] == hmd_pkg::PATH_TEST) ?
                  hmd_pkg::ANS_T_STAT :
                  {header[7:6], hmd_pkg::ANS_STATUS, blk}; // [R10]
               next_ack    = 1'b1;
            end
            hmd_pkg::HMD_CFG_SET: begin
               if (blk == hmd_pkg::BLK_SLOT) begin
                  next_slot_cfg = ctrl_hi; // [R12]
               end else if (blk == hmd_pkg::BLK_PUMP) begin
                  next_pump_mode = ctrl_hi;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state       <= HMD_WAIT_HDR;
         header      <= 8'h00;
         ctrl_hi     <= 8'h00;
         param_count <= 8'h00;
         param_idx   <= 8'h00;
         answer      <= 8'h00;
         ack         <= 1'b0;
         started     <= 1'b0;
         pump_mode   <= 8'h00;
         slot_cfg    <= 8'h00;
         event_code  <= 8'h00;
         valid_q     <= 1'b0;
         cls_q       <= 8'h00;
      end else begin
         state       <= next_state;
         header      <= next_header;
         ctrl_hi     <= next_ctrl_hi;
         param_count <= next_param_count;
         param_idx   <= next_param_idx;
         answer      <= next_answer;
         ack         <= next_ack;
         started     <= next_started;
         pump_mode   <= next_pump_mode;
         slot_cfg    <= next_slot_cfg;
         event_code  <= next_event_code;
         valid_q     <= next_valid;
         cls_q       <= next_cls;
      end
   end

   // parameter store, no reset needed for data
   always_ff @(posedge hclk) begin
      if (pwr_en) begin
         params[pwr_idx] <= wbyte;
      end
   end

   always_comb begin
      hrdata = 32'h0000_0000;
      if (ap_rd) begin
         unique case (ap_addr)
            hmd_pkg::OFS_HEADER: hrdata = {24'h0, header};
            hmd_pkg::OFS_CTRL:   hrdata = {16'h0, ctrl_hi, param_count};
            hmd_pkg::OFS_PARAM:  hrdata = {24'h0, params[param_idx[5:0]]};
            hmd_pkg::OFS_STATUS: hrdata = {22'h0, started, ack,
                                           param_idx[5:0], state};
            hmd_pkg::OFS_DECODE: hrdata = {24'h0, cls_q};
            hmd_pkg::OFS_ACK:    hrdata = {23'h0, ack, answer};
            hmd_pkg::OFS_PUMP:   hrdata = {24'h0, pump_mode};
            hmd_pkg::OFS_SLOT:   hrdata = {24'h0, slot_cfg};
            hmd_pkg::OFS_EVENT:  hrdata = {24'h0, event_code};
            default:             hrdata = 32'h0000_0000;
         endcase
      end
   end

   assign msg_valid       = valid_q;
   assign msg_class_out   = cls_q;
   assign msg_path        = header[7:6];
   assign msg_block       = header[1:0];
   assign program_started = started;

   hdr_order_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
      (state == HMD_WAIT_HI && $past(state) != HMD_WAIT_HI)
      |-> $past(wr_now))
      else $error("control byte stage without prior write");
   param_cnt_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
      (state == HMD_PARAMS) |-> (param_idx < param_count))
      else $error("parameter index overran count");
   dl_block_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
      (started && header[7:6] == 2'b00 && header[5:0] == 6'h08)
      |-> cls == hmd_pkg::HMD_INVALID)
      else $error("download code accepted after start");
   invalid_ans_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
      (next_valid && cls == hmd_pkg::HMD_INVALID && !pump_event)
      |=> (answer == 8'h3F && ack))
      else $error("invalid header not answered");
   tx_code_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
      (header[7] != header[6] && header[5:0] == hmd_pkg::CODE_CTRL_TX)
      |-> cls == hmd_pkg::HMD_CTRL_TX)
      else $error("transmit code not recognised");
   cfg_ans_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
      (next_valid && cls == hmd_pkg::HMD_CFG_REQ && !pump_event)
      |=> (ack && answer[5:2] == 4'h9))
      else $error("config request unanswered");
   slot_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R12]
      (next_valid && cls == hmd_pkg::HMD_CFG_SET && blk == 2'b11)
      |=> slot_cfg == $past(ctrl_hi))
      else $error("timeslot setup not stored");
   event_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
      pump_event |=> (ack && event_code == $past(pump_event_code)))
      else $error("pump event not posted");
endmodule

// file: design/hmd_pkg.sv
package hmd_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_HEADER    = 8'h00;
   localparam logic [7:0] OFS_CTRL      = 8'h04;
   localparam logic [7:0] OFS_PARAM     = 8'h08;
   localparam logic [7:0] OFS_STATUS    = 8'h0C;
   localparam logic [7:0] OFS_DECODE    = 8'h10;
   localparam logic [7:0] OFS_ACK       = 8'h14;
   localparam logic [7:0] OFS_PUMP      = 8'h18;
   localparam logic [7:0] OFS_SLOT      = 8'h1C;
   localparam logic [7:0] OFS_EVENT     = 8'h20;
   // header fields
   localparam int PATH_HI = 7;
   localparam int PATH_LO = 6;
   localparam int TYPE_HI = 5;
   localparam int TYPE_LO = 2;
   localparam int BLK_HI  = 1;
   localparam int BLK_LO  = 0;
   localparam logic [1:0] PATH_TEST = 2'b00;
   localparam logic [1:0] PATH_ONE  = 2'b01;
   localparam logic [1:0] PATH_TWO  = 2'b10;
   localparam logic [1:0] BLK_BUFFER = 2'b00;
   localparam logic [1:0] BLK_SFU    = 2'b01;
   localparam logic [1:0] BLK_PUMP   = 2'b10;
   localparam logic [1:0] BLK_SLOT   = 2'b11;
   localparam logic [3:0] TYP_CFG_REQ  = 4'h1;
   localparam logic [3:0] TYP_STAT_REQ = 4'h3;
   localparam logic [3:0] TYP_CFG_SET  = 4'h9;
   localparam logic [3:0] TYP_CTRL     = 4'hA;
   localparam logic [5:0] CODE_CTRL_TX = 6'h20;
   // test path codes
   localparam logic [5:0] T_CFG_SET   = 6'h3C;
   localparam logic [5:0] T_CTRL      = 6'h3E;
   localparam logic [5:0] T_STAT_REQ  = 6'h1D;
   localparam logic [5:0] T_WAIT_CFG  = 6'h27;
   localparam logic [5:0] T_TIMER_CFG = 6'h25;
   localparam logic [5:0] T_SELFTEST  = 6'h05;
   localparam logic [5:0] T_CHIP_VER  = 6'h14;
   localparam logic [5:0] T_KEY       = 6'h02;
   localparam logic [5:0] T_PROG      = 6'h1E;
   localparam logic [5:0] T_START     = 6'h08;
   // answer headers
   localparam logic [7:0] ANS_INVALID = 8'h3F;
   localparam logic [3:0] ANS_CFG     = 4'h9;
   localparam logic [3:0] ANS_EVENT   = 4'hA;
   localparam logic [3:0] ANS_STATUS  = 4'hB;
   localparam logic [7:0] ANS_T_STAT  = 8'h3D;
   // decoded message classes
   typedef enum logic [3:0] {
      HMD_NONE, HMD_CFG_REQ, HMD_STAT_REQ, HMD_CFG_SET, HMD_CTRL,
      HMD_CTRL_TX, HMD_WAIT_CFG, HMD_TIMER_CFG, HMD_SELFTEST,
      HMD_CHIP_VER, HMD_KEY, HMD_PROG, HMD_START, HMD_INVALID
   } hmd_class_t;
   localparam int PARAM_DEPTH = 64;
endpackage

// file: test/hmd_decoder_tb.sv
module hmd_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk, hresetn, hsel, hwrite, hready, hresp, pump_event;
   logic        msg_valid, program_started;
   logic [7:0]  haddr, msg_class_out, pump_event_code;
   logic [1:0]  htrans, msg_path, msg_block;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata;
   int          fail_count, n_tests, n_valid;

   hmd_decoder dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .pump_event(pump_event),
      .pump_event_code(pump_event_code), .msg_valid(msg_valid),
      .msg_class_out(msg_class_out), .msg_path(msg_path),
      .msg_block(msg_block), .program_started(program_started));
   hmd_host host (.hclk(hclk), .hready(hready), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk)
      if (msg_valid === 1'b1)
         n_valid++;

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic c, input string m);
      n_tests++;
      if (c !== 1'b1) begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      logic ok;
      host.xfer(wr, a, wd, rd, ok);
      if (!ok) begin
         check(1'b0, "bus timeout");
         report_and_stop();
      end
   endtask
   task automatic reset_dut();
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
   endtask
   // header, control high, control low = n, then n parameter bytes
   task automatic send(input logic [7:0] hdr, input logic [7:0] hi,
                       input int n, input logic [7:0] cls);
      logic [31:0] q;
      int v0, i;
      v0 = n_valid;
      bus(1'b1, hmd_pkg::OFS_HEADER, {24'h0, hdr}, q);
      bus(1'b1, hmd_pkg::OFS_CTRL, {24'h0, hi}, q);
      bus(1'b1, hmd_pkg::OFS_CTRL, n, q);
      if (n > 0) begin
         bus(1'b0, hmd_pkg::OFS_STATUS, 32'h0, q);
         check(q[7:2] === 6'h00, "mailbox pointer not cleared");
      end
      for (i = 0; i < n; i++) begin
         @(posedge hclk);
         check(n_valid == v0, "early message end");
         bus(1'b1, hmd_pkg::OFS_PARAM, i + 8'h11, q);
      end
      i = 0;
      while (n_valid == v0 && i < 10) begin
         @(posedge hclk);
         i++;
      end
      check(n_valid == v0 + 1, "no message end");
      check(msg_class_out === cls, "wrong class");
   endtask
   task automatic ans(input logic [8:0] e);
      logic [31:0] q;
      bus(1'b0, hmd_pkg::OFS_ACK, 32'h0, q);
      check(q[8:0] === e, "wrong answer");
   endtask

   task automatic t_reset();
      logic [31:0] q;
      check({msg_valid, msg_class_out, program_started, hresp} === 11'h0
            && hready === 1'b1, "reset outputs");
      bus(1'b0, hmd_pkg::OFS_STATUS, 32'h0, q);
      check(q === 32'h0, "status after reset");
      bus(1'b0, 8'hF0, 32'h0, q);
      check(q === 32'h0, "unmapped read");
   endtask
   task automatic t_regular();
      logic [3:0] ty [4] = '{hmd_pkg::TYP_CFG_REQ, hmd_pkg::TYP_STAT_REQ,
                             hmd_pkg::TYP_CFG_SET, hmd_pkg::TYP_CTRL};
      hmd_pkg::hmd_class_t cl [4] = '{hmd_pkg::HMD_CFG_REQ,
         hmd_pkg::HMD_STAT_REQ, hmd_pkg::HMD_CFG_SET, hmd_pkg::HMD_CTRL};
      int t, b;
      for (t = 0; t < 4; t++)
         for (b = 0; b < 4; b++) begin
            send({2'(1 + t % 2), ty[t], 2'(b)}, 8'h00, 0, {4'h0, cl[t]});
            check(msg_path === 2'(1 + t % 2) && msg_block === 2'(b),
                  "path or block");
         end
      send({hmd_pkg::PATH_TWO, hmd_pkg::CODE_CTRL_TX}, 8'h00, 2,
           {4'h0, hmd_pkg::HMD_CTRL_TX});
      send(8'hC4, 8'h00, 0, {4'h0, hmd_pkg::HMD_INVALID});
      ans({1'b1, hmd_pkg::ANS_INVALID});
      send(8'h40, 8'h00, 0, {4'h0, hmd_pkg::HMD_INVALID});
   endtask
   task automatic t_test_path();
      logic [5:0] cd [10] = '{hmd_pkg::T_CFG_SET, hmd_pkg::T_CTRL,
         hmd_pkg::T_STAT_REQ, hmd_pkg::T_WAIT_CFG, hmd_pkg::T_TIMER_CFG,
         hmd_pkg::T_SELFTEST, hmd_pkg::T_CHIP_VER, hmd_pkg::T_KEY,
         hmd_pkg::T_PROG, hmd_pkg::T_START};
      hmd_pkg::hmd_class_t cx [10] = '{hmd_pkg::HMD_CFG_SET,
         hmd_pkg::HMD_CTRL, hmd_pkg::HMD_STAT_REQ, hmd_pkg::HMD_WAIT_CFG,
         hmd_pkg::HMD_TIMER_CFG, hmd_pkg::HMD_SELFTEST,
         hmd_pkg::HMD_CHIP_VER, hmd_pkg::HMD_KEY, hmd_pkg::HMD_PROG,
         hmd_pkg::HMD_START};
      int i;
      for (i = 0; i < 10; i++)
         send({2'b00, cd[i]}, 8'h00, 0, {4'h0, cx[i]});
      check(program_started === 1'b1, "program not started");
      for (i = 6; i < 10; i++)
         send({2'b00, cd[i]}, 8'h00, 0, {4'h0, hmd_pkg::HMD_INVALID});
      send({2'b00, cd[0]}, 8'h00, 1, {4'h0, hmd_pkg::HMD_CFG_SET});
      send({2'b00, cd[2]}, 8'h00, 0, {4'h0, hmd_pkg::HMD_STAT_REQ});
      ans({1'b1, hmd_pkg::ANS_T_STAT});
      reset_dut();
      check(program_started === 1'b0, "start survives reset");
   endtask
   task automatic t_answers();
      logic [31:0] q;
      send(8'h46, 8'h00, 0, {4'h0, hmd_pkg::HMD_CFG_REQ});
      ans({1'b1, 2'b01, hmd_pkg::ANS_CFG, 2'b10});
      bus(1'b1, hmd_pkg::OFS_ACK, 32'h0, q);
      ans({1'b0, 2'b01, hmd_pkg::ANS_CFG, 2'b10});
      send(8'h8E, 8'h00, 0, {4'h0, hmd_pkg::HMD_STAT_REQ});
      ans({1'b1, 2'b10, hmd_pkg::ANS_STATUS, 2'b10});
      send(8'h66, 8'h5A, 0, {4'h0, hmd_pkg::HMD_CFG_SET});
      bus(1'b0, hmd_pkg::OFS_PUMP, 32'h0, q);
      check(q[7:0] === 8'h5A, "pump mode");
      send(8'hA7, 8'hC3, 1, {4'h0, hmd_pkg::HMD_CFG_SET});
      bus(1'b0, hmd_pkg::OFS_SLOT, 32'h0, q);
      check(q[7:0] === 8'hC3, "timeslot setting");
      pump_event      <= 1'b1;
      pump_event_code <= 8'h9D;
      @(posedge hclk);
      pump_event      <= 1'b0;
      pump_event_code <= 8'h62;
      bus(1'b0, hmd_pkg::OFS_EVENT, 32'h0, q);
      check(q[7:0] === 8'h9D, "event code");
      ans({1'b1, 8'h6A});
   endtask

   initial begin
      hresetn         = 1'b0;
      pump_event      = 1'b0;
      pump_event_code = 8'h00;
      fail_count      = 0;
      n_tests         = 0;
      n_valid         = 0;
      reset_dut();
      t_reset();
      t_regular();
      t_test_path();
      t_answers();
      report_and_stop();
   end
endmodule

// file: test/hmd_host.sv
module hmd_host (
   // bus clock and handshake
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // master side
   output logic             hsel,
   output logic [7:0]       haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      hsel   = 1'b0;
      haddr  = 8'h00;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h0;
   end

   // one single word transfer; ok low if the slave never answers
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic ok);
      int i;
      ok = 1'b1;
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= wr;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hready !== 1'b1 && i < 50);
      htrans <= 2'b00;
      hwdata <= wd;
      do begin
         @(posedge hclk);
         i++;
      end while (hready !== 1'b1 && i < 100);
      rd = hrdata;
      if (i >= 100)
         ok = 1'b0;
      // released data lines must not hold the old value
      hwdata <= ~wd;
      hsel   <= 1'b0;
   endtask
endmodule
